// >>> dit_load.sv
// external load on one toggle pin: cycles between pin edges
// assumes the pin settles before each rising edge of mclk
`timescale 1ns/1ps
module dit_load (
  input wire logic mclk,
  input wire logic pin,
  input wire logic arm,
  output logic [15:0] gap,
  output logic gap_valid
);
  logic prev;
  logic seen;
  logic [15:0] cnt;

  // first edge after arming only starts the count
  always_ff @(posedge mclk) begin
    prev <= pin;
    gap_valid <= 1'b0;
    cnt <= cnt + 16'h0001;
    if (!arm) begin
      seen <= 1'b0;
    end else if (pin != prev) begin
      seen <= 1'b1;
      cnt <= 16'h0001;
      gap <= cnt;
      gap_valid <= seen;
    end
  end
endmodule

// >>> dit_pkg.sv
// constants, types and register map of the dual interval timer
// assumes a classic wishbone slave with 8-bit data in the low byte
// What this block does
// R1: each timer has its own 6-bit prescaler dividing the cycle clock
// R2: timer a period is (period register + 1) times 4, 16 or 64 cycles
// R3: timer b period is (period register + 1) times 4, 16 or 64 cycles
// R4: timer a select codes 01,10,11 pick 4,16,64; 00 holds it in reset
// R5: timer b select codes 01,10,11 pick 4,16,64; 00 holds it in reset
// R6: timer a count after matching period wraps to 0 and sets overflow
// R7: timer b count after matching period wraps to 0 and sets overflow
// R8: timer a counter stays at zero while its select is 00
// R9: timer b counter stays at zero while its select is 00
// R10: period a write while running clears prescaler and counter
// R11: period b write while running clears prescaler and counter
// R12: timer a toggle output has half-period equal to timer a period
// R13: timer b toggle output has half-period equal to timer b period
// R14: one shared interrupt when any overflow flag and its enable are set
// R15: timer b overflow flag at bit 3 stays set until software clears it
// R16: control bits 7:6 select timer b clock, bits 5:4 timer a clock
// R17: timer a overflow flag at bit 1 stays set until software clears it
// R18: enables at bits 0 (a) and 2 (b) gate flags onto the request
// R19: output-enable bit 7 ORs timer b toggle onto latch in output mode
// R20: output-enable bit 6 ORs timer a toggle onto latch in output mode
// R21: toggle flips on each overflow and holds while timer is stopped
package dit_pkg;
  localparam logic [15:0] DIT_ADR_PFC = 16'hFE42;
  localparam logic [15:0] DIT_ADR_CTL = 16'hFE78;
  localparam logic [15:0] DIT_ADR_PA = 16'hFE7A;
  localparam logic [15:0] DIT_ADR_PB = 16'hFE7B;
  localparam logic [7:0] DIT_RST_VAL = 8'h00;
  localparam int DIT_B_CSEL_HI = 7;
  localparam int DIT_A_CSEL_HI = 5;
  localparam int DIT_B_OV = 3;
  localparam int DIT_B_IE = 2;
  localparam int DIT_A_OV = 1;
  localparam int DIT_A_IE = 0;
  localparam int DIT_B_OE = 7;
  localparam int DIT_A_OE = 6;
  localparam logic [1:0] DIT_CSEL_OFF = 2'h0;
  localparam logic [1:0] DIT_CSEL_4 = 2'h1;
  localparam logic [1:0] DIT_CSEL_16 = 2'h2;
  localparam logic [5:0] DIT_DIV4_MAX = 6'h03;
  localparam logic [5:0] DIT_DIV16_MAX = 6'h0F;
  localparam logic [5:0] DIT_DIV64_MAX = 6'h3F;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [7:0] dat;
  } dit_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [7:0] dat;
  } dit_wb_rsp_t;

  typedef struct packed {
    logic latch;
    logic out_mode;
  } dit_port_t;
endpackage

// >>> dit_timer.sv
// dual 8-bit interval timer with prescalers, flags and toggle outputs
// assumes one 40 MHz clock, synchronous reset, wishbone master in same domain
`timescale 1ns/1ps
module dit_timer (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire dit_pkg::dit_wb_req_t wb_req,
  output dit_pkg::dit_wb_rsp_t wb_rsp,
  input wire dit_pkg::dit_port_t port_a,
  input wire dit_pkg::dit_port_t port_b,
  output logic timer_a_toggle_pin,
  output logic timer_b_toggle_pin,
  output logic irq
);
  import dit_pkg::*;

  default clocking dit_cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  function automatic logic [5:0] div_max(input logic [1:0] sel);
    if (sel == DIT_CSEL_4) begin
      div_max = DIT_DIV4_MAX;
    end else if (sel == DIT_CSEL_16) begin
      div_max = DIT_DIV16_MAX;
    end else begin
      div_max = DIT_DIV64_MAX;
    end
  endfunction

  logic [7:0] timer_pair_control;
  logic [7:0] port_function_control;
  logic [7:0] timer_a_period;
  logic [7:0] timer_b_period;
  logic [5:0] timer_a_prescaler;
  logic [5:0] timer_b_prescaler;
  logic [7:0] timer_a_counter;
  logic [7:0] timer_b_counter;
  logic timer_a_toggle;
  logic timer_b_toggle;
  logic ack;
  logic [7:0] rdat;

  wire bus_req = wb_req.cyc & wb_req.stb & ~ack;
  wire bus_wr = bus_req & wb_req.we;
  wire hit_ctl = wb_req.adr == DIT_ADR_CTL;
  wire hit_pfc = wb_req.adr == DIT_ADR_PFC;
  wire hit_pa = wb_req.adr == DIT_ADR_PA;
  wire hit_pb = wb_req.adr == DIT_ADR_PB;
  wire wr_ctl = bus_wr & hit_ctl;
  wire wr_pa = bus_wr & hit_pa;
  wire wr_pb = bus_wr & hit_pb;

  wire [1:0] timer_a_clksel = timer_pair_control[DIT_A_CSEL_HI -: 2]; // R16
  wire [1:0] timer_b_clksel = timer_pair_control[DIT_B_CSEL_HI -: 2]; // R16
  wire timer_a_run = timer_a_clksel != DIT_CSEL_OFF; // R4
  wire timer_b_run = timer_b_clksel != DIT_CSEL_OFF; // R5
  wire timer_a_tick = timer_a_run &&
    timer_a_prescaler == div_max(timer_a_clksel); // R1 R2
  wire timer_b_tick = timer_b_run &&
    timer_b_prescaler == div_max(timer_b_clksel); // R1 R3
  wire timer_a_ovf = timer_a_tick && timer_a_counter == timer_a_period; // R6
  wire timer_b_ovf = timer_b_tick && timer_b_counter == timer_b_period; // R7
  wire timer_a_clr = ~timer_a_run | wr_pa; // R8 R10
  wire timer_b_clr = ~timer_b_run | wr_pb; // R9 R11

  // software writes a flag, hardware set wins
  wire next_a_ov = timer_a_ovf |
    (wr_ctl ? wb_req.dat[DIT_A_OV] : timer_pair_control[DIT_A_OV]); // R17
  wire next_b_ov = timer_b_ovf |
    (wr_ctl ? wb_req.dat[DIT_B_OV] : timer_pair_control[DIT_B_OV]); // R15
  wire [7:0] ctl_base = wr_ctl ? wb_req.dat : timer_pair_control;
  wire [7:0] next_ctl = {ctl_base[7:4], next_b_ov, ctl_base[DIT_B_IE],
    next_a_ov, ctl_base[DIT_A_IE]};

  wire [7:0] next_rdat = hit_ctl ? timer_pair_control :
    hit_pfc ? port_function_control :
    hit_pa ? timer_a_period :
    hit_pb ? timer_b_period : 8'h00;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_pair_control <= DIT_RST_VAL;
      port_function_control <= DIT_RST_VAL;
      timer_a_period <= DIT_RST_VAL;
      timer_b_period <= DIT_RST_VAL;
    end else begin
      timer_pair_control <= next_ctl;
      if (bus_wr && hit_pfc) begin
        port_function_control <= wb_req.dat;
      end
      if (wr_pa) begin
        timer_a_period <= wb_req.dat;
      end
      if (wr_pb) begin
        timer_b_period <= wb_req.dat;
      end
    end
  end

  // one wait-free answer cycle, unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack <= 1'b0;
      rdat <= 8'h00;
    end else begin
      ack <= bus_req;
      if (bus_req) begin
        rdat <= next_rdat;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || timer_a_clr) begin
      timer_a_prescaler <= 6'h00;
      timer_a_counter <= 8'h00;
    end else begin
      timer_a_prescaler <= timer_a_tick ? 6'h00 : timer_a_prescaler + 6'h01;
      if (timer_a_tick) begin
        timer_a_counter <= timer_a_ovf ? 8'h00 : timer_a_counter + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || timer_b_clr) begin
      timer_b_prescaler <= 6'h00;
      timer_b_counter <= 8'h00;
    end else begin
      timer_b_prescaler <= timer_b_tick ? 6'h00 : timer_b_prescaler + 6'h01;
      if (timer_b_tick) begin
        timer_b_counter <= timer_b_ovf ? 8'h00 : timer_b_counter + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_a_toggle <= 1'b0;
      timer_b_toggle <= 1'b0;
    end else begin
      if (timer_a_ovf) begin
        timer_a_toggle <= ~timer_a_toggle; // R12 R21
      end
      if (timer_b_ovf) begin
        timer_b_toggle <= ~timer_b_toggle; // R13 R21
      end
    end
  end

  wire a_oe = port_function_control[DIT_A_OE] & port_a.out_mode;
  wire b_oe = port_function_control[DIT_B_OE] & port_b.out_mode;
  assign timer_a_toggle_pin = port_a.latch | (a_oe & timer_a_toggle); // R20
  assign timer_b_toggle_pin = port_b.latch | (b_oe & timer_b_toggle); // R19
  assign irq = (timer_pair_control[DIT_A_OV] & timer_pair_control[DIT_A_IE])
    | (timer_pair_control[DIT_B_OV] & timer_pair_control[DIT_B_IE]); // R14 R18
  assign wb_rsp.ack = ack;
  assign wb_rsp.dat = rdat;

  a_div_four_a: assert property ( // R2
    (timer_a_clksel == DIT_CSEL_4 && timer_a_tick && !wr_pa && !wr_ctl)
      ##1 (timer_a_clksel == DIT_CSEL_4 && !wr_pa && !wr_ctl)[*3]
      |=> timer_a_tick)
    else $error("timer a prescaler not dividing by four");

  b_div_four_a: assert property ( // R3
    (timer_b_clksel == DIT_CSEL_4 && timer_b_tick && !wr_pb && !wr_ctl)
      ##1 (timer_b_clksel == DIT_CSEL_4 && !wr_pb && !wr_ctl)[*3]
      |=> timer_b_tick)
    else $error("timer b prescaler not dividing by four");

  a_pre_step_a: assert property ( // R1
    timer_a_run && !timer_a_tick && !timer_a_clr
      |=> timer_a_prescaler == $past(timer_a_prescaler) + 6'h01)
    else $error("timer a prescaler did not advance");

  b_pre_step_a: assert property ( // R1
    timer_b_run && !timer_b_tick && !timer_b_clr
      |=> timer_b_prescaler == $past(timer_b_prescaler) + 6'h01)
    else $error("timer b prescaler did not advance");

  a_pre_wrap_a: assert property ( // R2
    timer_a_tick |=> timer_a_prescaler == 6'h00)
    else $error("timer a prescaler did not restart");

  b_pre_wrap_a: assert property ( // R3
    timer_b_tick |=> timer_b_prescaler == 6'h00)
    else $error("timer b prescaler did not restart");

  a_count_step_a: assert property ( // R6
    timer_a_tick && !timer_a_ovf && !timer_a_clr
      |=> timer_a_counter == $past(timer_a_counter) + 8'h01)
    else $error("timer a counter did not step");

  b_count_step_a: assert property ( // R7
    timer_b_tick && !timer_b_ovf && !timer_b_clr
      |=> timer_b_counter == $past(timer_b_counter) + 8'h01)
    else $error("timer b counter did not step");

  a_count_hold_a: assert property ( // R2
    !timer_a_tick && !timer_a_clr |=> $stable(timer_a_counter))
    else $error("timer a counter moved without tick");

  b_count_hold_a: assert property ( // R3
    !timer_b_tick && !timer_b_clr |=> $stable(timer_b_counter))
    else $error("timer b counter moved without tick");

  a_stop_zero_a: assert property ( // R8
    !timer_a_run |=> timer_a_counter == 8'h00 && timer_a_prescaler == 6'h00)
    else $error("timer a not held at zero while stopped");

  b_stop_zero_a: assert property ( // R9
    !timer_b_run |=> timer_b_counter == 8'h00 && timer_b_prescaler == 6'h00)
    else $error("timer b not held at zero while stopped");

  a_wrap_flag_a: assert property ( // R6
    timer_a_ovf |=> timer_a_counter == 8'h00 && timer_pair_control[DIT_A_OV])
    else $error("timer a wrap without flag");

  b_wrap_flag_a: assert property ( // R7
    timer_b_ovf |=> timer_b_counter == 8'h00 && timer_pair_control[DIT_B_OV])
    else $error("timer b wrap without flag");

  a_period_clear_a: assert property ( // R10
    wr_pa |=> timer_a_prescaler == 6'h00 && timer_a_counter == 8'h00)
    else $error("period a write did not restart timer");

  b_period_clear_a: assert property ( // R11
    wr_pb |=> timer_b_prescaler == 6'h00 && timer_b_counter == 8'h00)
    else $error("period b write did not restart timer");

  a_flag_sticky_a: assert property ( // R17
    timer_pair_control[DIT_A_OV] && !wr_ctl |=> timer_pair_control[DIT_A_OV])
    else $error("timer a flag dropped without software");

  b_flag_sticky_a: assert property ( // R15
    timer_pair_control[DIT_B_OV] && !wr_ctl |=> timer_pair_control[DIT_B_OV])
    else $error("timer b flag dropped without software");

  a_flag_clear_a: assert property ( // R17
    wr_ctl && !wb_req.dat[DIT_A_OV] && !timer_a_ovf
      |=> !timer_pair_control[DIT_A_OV])
    else $error("timer a flag not cleared by software");

  b_flag_clear_a: assert property ( // R15
    wr_ctl && !wb_req.dat[DIT_B_OV] && !timer_b_ovf
      |=> !timer_pair_control[DIT_B_OV])
    else $error("timer b flag not cleared by software");

  a_set_wins_a: assert property ( // R17
    timer_a_ovf && wr_ctl |=> timer_pair_control[DIT_A_OV])
    else $error("timer a overflow lost to a write");

  b_set_wins_a: assert property ( // R15
    timer_b_ovf && wr_ctl |=> timer_pair_control[DIT_B_OV])
    else $error("timer b overflow lost to a write");

  a_flag_cause_a: assert property ( // R6
    !timer_pair_control[DIT_A_OV] && !timer_a_ovf &&
      !(wr_ctl && wb_req.dat[DIT_A_OV]) |=> !timer_pair_control[DIT_A_OV])
    else $error("timer a flag set without cause");

  b_flag_cause_a: assert property ( // R7
    !timer_pair_control[DIT_B_OV] && !timer_b_ovf &&
      !(wr_ctl && wb_req.dat[DIT_B_OV]) |=> !timer_pair_control[DIT_B_OV])
    else $error("timer b flag set without cause");

  a_toggle_hold_a: assert property ( // R21
    !timer_a_ovf |=> $stable(timer_a_toggle))
    else $error("timer a toggle moved without overflow");

  b_toggle_hold_a: assert property ( // R21
    !timer_b_ovf |=> $stable(timer_b_toggle))
    else $error("timer b toggle moved without overflow");

  a_toggle_flip_a: assert property ( // R12
    timer_a_ovf |=> timer_a_toggle != $past(timer_a_toggle))
    else $error("timer a toggle did not flip");

  b_toggle_flip_a: assert property ( // R13
    timer_b_ovf |=> timer_b_toggle != $past(timer_b_toggle))
    else $error("timer b toggle did not flip");

  irq_a_gate_a: assert property ( // R14
    $rose(timer_pair_control[DIT_A_OV]) && timer_pair_control[DIT_A_IE]
      |-> irq)
    else $error("enabled timer a overflow did not raise request");

  irq_b_gate_a: assert property ( // R14
    $rose(timer_pair_control[DIT_B_OV]) && timer_pair_control[DIT_B_IE]
      |-> irq)
    else $error("enabled timer b overflow did not raise request");

  irq_off_a: assert property ( // R18
    !timer_pair_control[DIT_A_IE] && !timer_pair_control[DIT_B_IE] |-> !irq)
    else $error("request raised with both enables clear");

  ctl_write_a: assert property ( // R16
    wr_ctl |=> (timer_pair_control & 8'hF5) == ($past(wb_req.dat) & 8'hF5))
    else $error("control write did not land");

  pfc_write_a: assert property ( // R19
    bus_wr && hit_pfc |=> port_function_control == $past(wb_req.dat))
    else $error("port function write did not land");

  pa_write_a: assert property ( // R10
    wr_pa |=> timer_a_period == $past(wb_req.dat))
    else $error("period a write did not land");

  ack_one_a: assert property (
    ack |=> !ack)
    else $error("ack held for more than one cycle");

  ack_follow_a: assert property (
    bus_req |=> ack)
    else $error("request not answered in one cycle");

  ack_cause_a: assert property (
    !bus_req |=> !ack)
    else $error("ack without request");

  pin_a_latch_a: assert property ( // R20
    port_a.latch |-> timer_a_toggle_pin)
    else $error("pin a lost its latch level");

  pin_a_plain_a: assert property ( // R20
    !a_oe |-> timer_a_toggle_pin == port_a.latch)
    else $error("pin a shows toggle while not enabled");

  pin_a_wave_a: assert property ( // R20
    a_oe && !port_a.latch |-> timer_a_toggle_pin == timer_a_toggle)
    else $error("pin a does not show toggle");

  pin_b_latch_a: assert property ( // R19
    port_b.latch |-> timer_b_toggle_pin)
    else $error("pin b lost its latch level");

  pin_b_plain_a: assert property ( // R19
    !b_oe |-> timer_b_toggle_pin == port_b.latch)
    else $error("pin b shows toggle while not enabled");

  pin_b_wave_a: assert property ( // R19
    b_oe && !port_b.latch |-> timer_b_toggle_pin == timer_b_toggle)
    else $error("pin b does not show toggle");

  a_ovf_c: cover property (@(posedge mclk) disable iff (sys_rst) timer_a_ovf);
  b_ovf_c: cover property (@(posedge mclk) disable iff (sys_rst)
    timer_b_ovf && timer_b_clksel == 2'h3);
  irq_c: cover property (@(posedge mclk) disable iff (sys_rst) $rose(irq));
  restart_c: cover property (@(posedge mclk) disable iff (sys_rst)
    wr_pa && timer_a_run);
endmodule

// >>> test_dit_timer.sv
// self-checking bench for dit_timer: registers, periods, flags, pins
// assumes dit_pkg and dit_load are compiled first
`timescale 1ns/1ps
module test_dit_timer;
  import dit_pkg::*;
  logic mclk, sys_rst, irq, pin_a, pin_b, arm_a, arm_b, va, vb;
  logic [15:0] ga, gb;
  dit_wb_req_t req;
  dit_wb_rsp_t rsp;
  dit_port_t pa, pb;
  int bad_count, total_checks;
  logic [8:0] rq[$];
  logic [15:0] qa[$], qb[$];
  logic [15:0] adr[5] = '{DIT_ADR_PFC, DIT_ADR_CTL, DIT_ADR_PA, DIT_ADR_PB,
    16'hFE79};

  dit_timer DUT (.mclk(mclk), .sys_rst(sys_rst), .wb_req(req),
    .wb_rsp(rsp), .port_a(pa), .port_b(pb), .timer_a_toggle_pin(pin_a),
    .timer_b_toggle_pin(pin_b), .irq(irq));
  dit_load LA (.mclk(mclk), .pin(pin_a), .arm(arm_a), .gap(ga),
    .gap_valid(va));
  dit_load LB (.mclk(mclk), .pin(pin_b), .arm(arm_b), .gap(gb),
    .gap_valid(vb));

  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // e[8] marks a read whose data is compared
  task automatic wb(logic we, logic [15:0] a, logic [7:0] d, logic [8:0] e);
    int n;
    n = 0;
    rq.push_back(e);
    @(posedge mclk);
    req <= '{1'b1, 1'b1, we, a, d};
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    chk("ack", 16'h0001, {15'h0000, rsp.ack});
    req <= '0;
    @(posedge mclk);
  endtask

  task automatic wr(logic [15:0] a, logic [7:0] d);
    wb(1'b1, a, d, 9'h000);
  endtask

  task automatic rd(logic [15:0] a, logic [7:0] e);
    wb(1'b0, a, 8'h00, {1'b1, e});
  endtask

  task automatic run(int t, logic [1:0] c);
    logic [7:0] ie, ctl, p;
    logic [15:0] g;
    logic lvl;
    ie = t ? 8'h04 : 8'h01;
    ctl = (t ? {c, 6'h00} : {2'b00, c, 4'h0}) | ie;
    p = 8'($urandom_range(7));
    g = ({8'h00, p} + 16'h0001) << (2 * c);
    wr(t ? DIT_ADR_PB : DIT_ADR_PA, p);
    rd(t ? DIT_ADR_PB : DIT_ADR_PA, p);
    wr(DIT_ADR_CTL, ctl);
    if (t) qb = '{g, g}; else qa = '{g, g};
    if (t) arm_b <= 1'b1; else arm_a <= 1'b1;
    for (int i = 0; i < 3000 && qa.size() + qb.size() > 0; i++)
      @(posedge mclk);
    chk("gaps left", 16'h0000, 16'(qa.size() + qb.size()));
    arm_a <= 1'b0;
    arm_b <= 1'b0;
    rd(DIT_ADR_CTL, ctl | (ie << 1));
    chk("irq set", 16'h0001, {15'h0000, irq});
    wr(DIT_ADR_CTL, ie | (ie << 1));
    lvl = t ? pin_b : pin_a;
    repeat (300) @(posedge mclk);
    chk("hold", {15'h0000, lvl}, {15'h0000, t ? pin_b : pin_a});
    wr(DIT_ADR_CTL, ie);
    chk("irq clear", 16'h0000, {15'h0000, irq});
    rd(DIT_ADR_CTL, ie);
    wr(DIT_ADR_CTL, 8'h00);
  endtask

  always @(posedge mclk) begin
    logic [8:0] e;
    if (rsp.ack === 1'b1 && rq.size() > 0) begin
      e = rq.pop_front();
      if (e[8]) chk("read data", {8'h00, e[7:0]}, {8'h00, rsp.dat});
    end
    if (va === 1'b1 && qa.size() > 0) chk("gap a", qa.pop_front(), ga);
    if (vb === 1'b1 && qb.size() > 0) chk("gap b", qb.pop_front(), gb);
  end

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    #1500000;
    bad_count++;
    complete_run();
  end

  initial begin
    sys_rst = 1'b1;
    req = '0;
    pa = '{1'b0, 1'b1};
    pb = '{1'b0, 1'b1};
    arm_a = 1'b0;
    arm_b = 1'b0;
    bad_count = 0;
    total_checks = 0;
    void'($urandom(32'h0E66));
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (adr[i]) rd(adr[i], 8'h00);
    wr(DIT_ADR_PFC, 8'hC0);
    rd(DIT_ADR_PFC, 8'hC0);
    for (int t = 0; t < 2; t++)
      for (int c = 1; c < 4; c++) run(t, 2'(c));
    pa <= '{1'b1, 1'b1};
    pb <= '{1'b0, 1'b0};
    @(posedge mclk);
    #1;
    chk("pin a latch", 16'h0001, {15'h0000, pin_a});
    chk("pin b input", 16'h0000, {15'h0000, pin_b});
    complete_run();
  end
endmodule
